/* src/rwsc_defs.svh */
// Register offsets, field positions and reset values of the reset, wake and strap block
`ifndef RWSC_DEFS_SVH
`define RWSC_DEFS_SVH

// Register byte offsets
`define RWSC_OFF_CTRL        8'h00
`define RWSC_OFF_STATUS      8'h04
`define RWSC_OFF_INT_STAT    8'h08
`define RWSC_OFF_INT_MASK    8'h0c

// Control register fields
`define RWSC_CTRL_WAKE_EN    0
`define RWSC_CTRL_WAKE_POL   1
`define RWSC_CTRL_WAKE_OD    2
`define RWSC_CTRL_SLEEP      3
`define RWSC_CTRL_W          4

// Status register fields
`define RWSC_ST_ASLEEP       0
`define RWSC_ST_READ_DONE    1
`define RWSC_ST_SPEED        2
`define RWSC_ST_BUS32        3
`define RWSC_ST_XOVER        4
`define RWSC_ST_WAKE_IND     5
`define RWSC_ST_STRAP_VALID  6

// Interrupt status and mask fields
`define RWSC_INT_WAKE_EVT    0
`define RWSC_INT_HOST_WAKE   1
`define RWSC_INT_WR_DROP     2
`define RWSC_INT_W           3

// Reset values
`define RWSC_CTRL_RST        4'h0
`define RWSC_INT_RST         3'h0
`define RWSC_MASK_RST        3'h0
`define RWSC_SPEED_RST       1'b1
`define RWSC_BUS32_RST       1'b1

// AXI responses
`define RWSC_RESP_OKAY       2'h0
`define RWSC_RESP_SLVERR     2'h2

`endif

/* src/rwsc_pkg.sv */
// Types shared by the reset, wake and strap block
package rwsc_pkg;

    typedef enum logic [0:0] {
        PWR_AWAKE = 1'b0,
        PWR_SLEEP = 1'b1
    } rwsc_pwr_t;

    typedef enum logic [2:0] {
        SEL_CTRL   = 3'h0,
        SEL_STATUS = 3'h1,
        SEL_INT    = 3'h2,
        SEL_MASK   = 3'h3,
        SEL_NONE   = 3'h4
    } rwsc_sel_t;

endpackage

/* src/rwsc_strap_latch.sv */
// Captures the speed and bus width straps when the hardware reset is released
`timescale 1ns/1ns
`include "rwsc_defs.svh"
module rwsc_strap_latch
    import rwsc_pkg::*;
(
    // Clock and resets
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    input  wire logic hw_reset_n_i,
    // Strap pins
    input  wire logic speed_strap_i,
    input  wire logic bus_width_strap_i,
    // Latched values
    output logic      speed_strap_o,
    output logic      bus_32bit_o,
    output logic      strap_valid_o
);

    // Valid drops in reset; first cycle after release captures
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            strap_valid_o <= 1'b0;
            speed_strap_o <= `RWSC_SPEED_RST;
            bus_32bit_o   <= `RWSC_BUS32_RST;
        end else if (!hw_reset_n_i) begin
            strap_valid_o <= 1'b0;
            speed_strap_o <= `RWSC_SPEED_RST;
            bus_32bit_o   <= `RWSC_BUS32_RST;
        end else if (!strap_valid_o) begin
            strap_valid_o <= 1'b1;
            speed_strap_o <= speed_strap_i;
            bus_32bit_o   <= bus_width_strap_i;
        end
    end

    chk_strap_capture: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        hw_reset_n_i && !strap_valid_o |=>
        strap_valid_o && speed_strap_o == $past(speed_strap_i)
        && bus_32bit_o == $past(bus_width_strap_i))
        else $error("strap not captured at reset release");

    chk_strap_hold: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        strap_valid_o && hw_reset_n_i |=> $stable(speed_strap_o) && $stable(bus_32bit_o))
        else $error("latched strap changed during operation");

endmodule // rwsc_strap_latch

/* src/rwsc_wake_pin.sv */
// Wake indicator pin driver with programmable polarity and push-pull or open-drain drive
`timescale 1ns/1ns
module rwsc_wake_pin
    import rwsc_pkg::*;
(
    // Clock and resets
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    input  wire logic hw_reset_n_i,
    // Control
    input  wire logic assert_i,
    input  wire logic active_high_i,
    input  wire logic open_drain_i,
    // Pin
    output logic      wake_indicator_o,
    output logic      wake_indicator_oe_o
);

    logic level;

    // Electrical level the pin should show
    assign level = active_high_i ? assert_i : ~assert_i;

    // Open drain only pulls low and releases otherwise
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wake_indicator_o    <= 1'b0;
            wake_indicator_oe_o <= 1'b0;
        end else if (!hw_reset_n_i) begin
            wake_indicator_o    <= 1'b0;
            wake_indicator_oe_o <= 1'b0;
        end else if (open_drain_i) begin
            wake_indicator_o    <= 1'b0;
            wake_indicator_oe_o <= ~level;
        end else begin
            wake_indicator_o    <= level;
            wake_indicator_oe_o <= 1'b1;
        end
    end

    chk_pin_push_pull: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        hw_reset_n_i && !open_drain_i |=>
        wake_indicator_oe_o && wake_indicator_o == ($past(assert_i) ~^ $past(active_high_i)))
        else $error("push-pull wake level wrong");

    chk_pin_open_drain: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        hw_reset_n_i && open_drain_i |=>
        !wake_indicator_o && wake_indicator_oe_o == ($past(assert_i) ^ $past(active_high_i)))
        else $error("open-drain wake drive wrong");

endmodule // rwsc_wake_pin

/* src/rwsc_top.sv */
// Reset, first-read gating, power-save wake, wake indicator and strap control
//
// Operation
// - Hardware reset low returns all logic to reset state except the AXI channel registers and the crossover enable output.
// - After reset or wake, host writes are ignored until one host read occurs.
// - When enabled, a wake event detected in power save asserts the wake indicator output.
// - Wake indicator has programmable polarity and push-pull or open-drain drive.
// - Wake events never leave power save; only a chip-selected host write does.
// - Any host write wakes the device from power save, whatever the data.
// - Crossover enable input high enables auto crossover, low disables it.
// - Speed strap is latched at reset release and picks default speed settings.
// - Bus width strap latched at reset release: high 32-bit, low 16-bit.
`timescale 1ns/1ns
`include "rwsc_defs.svh"
module rwsc_top
    import rwsc_pkg::*;
#(
    parameter int AXI_ADDR_W = 8
) (
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  reset_n_i,
    // Hardware reset pin
    input  wire logic                  hw_reset_n_i,
    // Host bus cycle pins
    input  wire logic                  chip_select_n_i,
    input  wire logic                  write_strobe_n_i,
    input  wire logic                  read_strobe_n_i,
    output logic                       host_write_accept_o,
    // Wake event source and indicator pin
    input  wire logic                  wake_event_i,
    output logic                       wake_indicator_o,
    output logic                       wake_indicator_oe_o,
    output logic                       power_save_o,
    // Straps and crossover
    input  wire logic                  speed_strap_i,
    input  wire logic                  bus_width_strap_i,
    input  wire logic                  auto_crossover_enable_i,
    output logic                       speed_strap_o,
    output logic                       bus_32bit_o,
    output logic                       auto_crossover_en_o,
    // Interrupt
    output logic                       irq_o,
    // AXI4-Lite write address and data
    input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // AXI4-Lite read
    input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready
);

    function automatic rwsc_sel_t reg_sel(input logic [AXI_ADDR_W-1:0] addr);
        unique case (addr[7:0])
            `RWSC_OFF_CTRL:     reg_sel = SEL_CTRL;
            `RWSC_OFF_STATUS:   reg_sel = SEL_STATUS;
            `RWSC_OFF_INT_STAT: reg_sel = SEL_INT;
            `RWSC_OFF_INT_MASK: reg_sel = SEL_MASK;
            default:            reg_sel = SEL_NONE;
        endcase
    endfunction

    rwsc_pwr_t                   pwr_r;
    logic [`RWSC_CTRL_W-1:0]     ctrl_r;
    logic [`RWSC_INT_W-1:0]      int_stat_r;
    logic [`RWSC_INT_W-1:0]      int_mask_r;
    logic [`RWSC_INT_W-1:0]      int_set;
    logic                        read_done_r;
    logic                        wake_pend_r;
    logic                        wr_cycle_r;
    logic                        rd_cycle_r;
    logic                        host_wr_start;
    logic                        host_rd_start;
    logic                        strap_valid;
    logic [AXI_ADDR_W-1:0]       awaddr_r;
    logic [31:0]                 wdata_r;
    logic [3:0]                  wstrb_r;
    logic                        aw_got_r;
    logic                        w_got_r;
    logic                        do_write;
    rwsc_sel_t                   wsel;
    logic [31:0]                 rd_word;
    logic                        sleep_req;

    assign power_save_o = (pwr_r == PWR_SLEEP);

    // Host cycle starts at the assertion of strobe with chip select
    assign host_wr_start = !chip_select_n_i && !write_strobe_n_i && !wr_cycle_r;
    assign host_rd_start = !chip_select_n_i && !read_strobe_n_i && !rd_cycle_r;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_cycle_r <= 1'b0;
            rd_cycle_r <= 1'b0;
        end else if (!hw_reset_n_i) begin
            wr_cycle_r <= 1'b0;
            rd_cycle_r <= 1'b0;
        end else begin
            wr_cycle_r <= !chip_select_n_i && !write_strobe_n_i;
            rd_cycle_r <= !chip_select_n_i && !read_strobe_n_i;
        end
    end

    // First read unlocks writes; waking from power save locks them again
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            read_done_r <= 1'b0;
        end else if (!hw_reset_n_i) begin
            read_done_r <= 1'b0;
        end else if (power_save_o && host_wr_start) begin
            read_done_r <= 1'b0;
        end else if (host_rd_start && !power_save_o) begin
            read_done_r <= 1'b1;
        end
    end

    // Accepted host write pulse, suppressed before the first read
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            host_write_accept_o <= 1'b0;
        end else if (!hw_reset_n_i) begin
            host_write_accept_o <= 1'b0;
        end else begin
            host_write_accept_o <= host_wr_start && read_done_r && !power_save_o;
        end
    end

    // Power state: software enters sleep, only a host write leaves it
    assign sleep_req = do_write && wsel == SEL_CTRL && wstrb_r[0]
                       && wdata_r[`RWSC_CTRL_SLEEP];

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pwr_r <= PWR_AWAKE;
        end else if (!hw_reset_n_i) begin
            pwr_r <= PWR_AWAKE;
        end else begin
            unique case (pwr_r)
                PWR_AWAKE: if (sleep_req) begin
                    pwr_r <= PWR_SLEEP;
                end
                PWR_SLEEP: if (host_wr_start) begin
                    pwr_r <= PWR_AWAKE;
                end
            endcase
        end
    end

    // Wake request held until the host wakes the device
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wake_pend_r <= 1'b0;
        end else if (!hw_reset_n_i) begin
            wake_pend_r <= 1'b0;
        end else if (power_save_o && wake_event_i && ctrl_r[`RWSC_CTRL_WAKE_EN]) begin
            wake_pend_r <= 1'b1;
        end else if (!power_save_o) begin
            wake_pend_r <= 1'b0;
        end
    end

    rwsc_wake_pin u_wake_pin (
        .clk_i               (clk_i),
        .reset_n_i           (reset_n_i),
        .hw_reset_n_i        (hw_reset_n_i),
        .assert_i            (wake_pend_r),
        .active_high_i       (ctrl_r[`RWSC_CTRL_WAKE_POL]),
        .open_drain_i        (ctrl_r[`RWSC_CTRL_WAKE_OD]),
        .wake_indicator_o    (wake_indicator_o),
        .wake_indicator_oe_o (wake_indicator_oe_o)
    );

    rwsc_strap_latch u_strap (
        .clk_i             (clk_i),
        .reset_n_i         (reset_n_i),
        .hw_reset_n_i      (hw_reset_n_i),
        .speed_strap_i     (speed_strap_i),
        .bus_width_strap_i (bus_width_strap_i),
        .speed_strap_o     (speed_strap_o),
        .bus_32bit_o       (bus_32bit_o),
        .strap_valid_o     (strap_valid)
    );

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            auto_crossover_en_o <= 1'b0;
        end else begin
            auto_crossover_en_o <= auto_crossover_enable_i;
        end
    end

    // AXI write: address and data taken in either order
    assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
    assign do_write      = aw_got_r && w_got_r && !s_axi_bvalid;
    assign wsel          = reg_sel(awaddr_r);

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            awaddr_r     <= '0;
            wdata_r      <= 32'h0;
            wstrb_r      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RWSC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wsel == SEL_NONE) ? `RWSC_RESP_SLVERR : `RWSC_RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Control and mask registers; the sleep bit reads the power state
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_r     <= `RWSC_CTRL_RST;
            int_mask_r <= `RWSC_MASK_RST;
        end else if (!hw_reset_n_i) begin
            ctrl_r     <= `RWSC_CTRL_RST;
            int_mask_r <= `RWSC_MASK_RST;
        end else if (do_write && wstrb_r[0]) begin
            if (wsel == SEL_CTRL) begin
                ctrl_r <= {1'b0, wdata_r[`RWSC_CTRL_WAKE_OD:0]};
            end
            if (wsel == SEL_MASK) begin
                int_mask_r <= wdata_r[`RWSC_INT_W-1:0];
            end
        end
    end

    // Sticky events, write one to clear, a new event beats the clear
    always_comb begin
        int_set = '0;
        int_set[`RWSC_INT_WAKE_EVT]  = power_save_o && wake_event_i;
        int_set[`RWSC_INT_HOST_WAKE] = power_save_o && host_wr_start;
        int_set[`RWSC_INT_WR_DROP]   = host_wr_start && !power_save_o && !read_done_r;
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            int_stat_r <= `RWSC_INT_RST;
        end else if (!hw_reset_n_i) begin
            int_stat_r <= `RWSC_INT_RST;
        end else if (do_write && wstrb_r[0] && wsel == SEL_INT) begin
            int_stat_r <= (int_stat_r & ~wdata_r[`RWSC_INT_W-1:0]) | int_set;
        end else begin
            int_stat_r <= int_stat_r | int_set;
        end
    end

    assign irq_o = |(int_stat_r & int_mask_r);

    // AXI read
    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        rd_word = 32'h0;
        unique case (reg_sel(s_axi_araddr))
            SEL_CTRL: begin
                rd_word[`RWSC_CTRL_W-1:0] = ctrl_r;
                rd_word[`RWSC_CTRL_SLEEP] = power_save_o;
            end
            SEL_STATUS: begin
                rd_word[`RWSC_ST_ASLEEP]      = power_save_o;
                rd_word[`RWSC_ST_READ_DONE]   = read_done_r;
                rd_word[`RWSC_ST_SPEED]       = speed_strap_o;
                rd_word[`RWSC_ST_BUS32]       = bus_32bit_o;
                rd_word[`RWSC_ST_XOVER]       = auto_crossover_en_o;
                rd_word[`RWSC_ST_WAKE_IND]    = wake_pend_r;
                rd_word[`RWSC_ST_STRAP_VALID] = strap_valid;
            end
            SEL_INT:  rd_word[`RWSC_INT_W-1:0] = int_stat_r;
            SEL_MASK: rd_word[`RWSC_INT_W-1:0] = int_mask_r;
            SEL_NONE: rd_word = 32'h0;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= `RWSC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= (reg_sel(s_axi_araddr) == SEL_NONE) ? `RWSC_RESP_SLVERR
                                                                : `RWSC_RESP_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    chk_hw_reset_clears: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !hw_reset_n_i |=> pwr_r == PWR_AWAKE && !read_done_r && ctrl_r == '0
        && int_stat_r == '0 && !wake_pend_r)
        else $error("hardware reset left state behind");

    chk_write_gated: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !read_done_r |=> !host_write_accept_o)
        else $error("write accepted before first read");

    chk_first_read: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        hw_reset_n_i && host_rd_start && !power_save_o |=> read_done_r)
        else $error("first read did not unlock writes");

    // Pin shows the asserted level for the drive and polarity in force
    chk_wake_request: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        hw_reset_n_i && power_save_o && wake_event_i && ctrl_r[`RWSC_CTRL_WAKE_EN]
        |=> wake_pend_r ##2 (!$past(wake_pend_r) || !$past(hw_reset_n_i)
            || ($past(ctrl_r[`RWSC_CTRL_WAKE_OD])
                ? wake_indicator_oe_o != $past(ctrl_r[`RWSC_CTRL_WAKE_POL])
                : wake_indicator_o == $past(ctrl_r[`RWSC_CTRL_WAKE_POL]))))
        else $error("wake event did not raise indicator");

    chk_event_no_wake: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        hw_reset_n_i && power_save_o && !host_wr_start |=> power_save_o)
        else $error("left power save without host write");

    chk_write_wakes: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        hw_reset_n_i && power_save_o && host_wr_start
        |=> !power_save_o && !read_done_r && int_stat_r[`RWSC_INT_HOST_WAKE])
        else $error("host write did not wake device");

    chk_xover_follow: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        1'b1 |=> auto_crossover_en_o == $past(auto_crossover_enable_i))
        else $error("crossover enable not following pin");

    chk_irq_level: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        hw_reset_n_i && (int_set & int_mask_r) != '0 |=> irq_o)
        else $error("masked event did not raise interrupt");

endmodule // rwsc_top

/* bench/rwsc_host_model.sv */
// Host processor model driving the chip select and strobe pins
`timescale 1ns/1ns
module rwsc_host_model (
    // Clock
    input  wire logic clk_i,
    // Host bus cycle pins
    output logic      chip_select_n_o = 1'h1,
    output logic      write_strobe_n_o = 1'h1,
    output logic      read_strobe_n_o = 1'h1
);
    // One bus cycle, strobes held two clocks
    task automatic cycle(input logic is_wr);
        @(posedge clk_i);
        chip_select_n_o <= 1'h0;
        write_strobe_n_o <= ~is_wr;
        read_strobe_n_o <= is_wr;
        repeat (2) @(posedge clk_i);
        {chip_select_n_o, write_strobe_n_o, read_strobe_n_o} <= 3'h7;
        @(posedge clk_i);
    endtask
endmodule // rwsc_host_model

/* bench/test_rwsc_top.sv */
// Self-checking bench for the reset, wake and strap block
`timescale 1ns/1ns
`include "rwsc_defs.svh"
module test_rwsc_top;
    localparam logic [1:0] OK = `RWSC_RESP_OKAY, ERR = `RWSC_RESP_SLVERR;
    localparam logic [7:0] CT = `RWSC_OFF_CTRL, ST = `RWSC_OFF_STATUS;
    localparam logic [7:0] IS = `RWSC_OFF_INT_STAT, MK = `RWSC_OFF_INT_MASK;
    logic clk_i = 1'h0, reset_n_i = 1'h0, hw_reset_n_i = 1'h1, wake_event_i = 1'h0;
    logic speed_strap_i = 1'h0, bus_width_strap_i = 1'h0, auto_crossover_enable_i = 1'h1;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    wire chip_select_n_i, write_strobe_n_i, read_strobe_n_i;
    logic host_write_accept_o, wake_indicator_o, wake_indicator_oe_o, power_save_o, irq_o;
    logic speed_strap_o, bus_32bit_o, auto_crossover_en_o;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int n_fail = 0, n_compared = 0, n_acc = 0;
    rwsc_top #(.AXI_ADDR_W(8)) i_rwsc_top (
        .clk_i, .reset_n_i, .hw_reset_n_i, .chip_select_n_i, .write_strobe_n_i,
        .read_strobe_n_i, .host_write_accept_o, .wake_event_i, .wake_indicator_o,
        .wake_indicator_oe_o, .power_save_o, .speed_strap_i, .bus_width_strap_i,
        .auto_crossover_enable_i, .speed_strap_o, .bus_32bit_o, .auto_crossover_en_o, .irq_o,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    rwsc_host_model i_rwsc_host_model (.clk_i, .chip_select_n_o(chip_select_n_i),
        .write_strobe_n_o(write_strobe_n_i), .read_strobe_n_o(read_strobe_n_i));
    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) if (host_write_accept_o === 1'h1) n_acc++;
    task automatic end_sim;
        if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w, b;
        logic [1:0] r;
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (int n = 0; n < 40; n++) begin
            @(negedge clk_i);
            {aw, w, b, r} = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready,
                s_axi_bvalid, s_axi_bresp};
            @(posedge clk_i);
            if (aw) s_axi_awvalid <= 1'h0;
            if (w) s_axi_wvalid <= 1'h0;
            if (b === 1'h1) begin
                s_axi_bready <= 1'h0;
                cmp("bresp", er, r);
                @(posedge clk_i);
                return;
            end
        end
        n_fail++;
        end_sim;
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar, v;
        logic [31:0] d;
        logic [1:0] r;
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (int n = 0; n < 40; n++) begin
            @(negedge clk_i);
            {ar, v, d, r} = {s_axi_arvalid & s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            @(posedge clk_i);
            if (ar) s_axi_arvalid <= 1'h0;
            if (v === 1'h1) begin
                s_axi_rready <= 1'h0;
                cmp("rdata", ed, d);
                cmp("rresp", er, r);
                @(posedge clk_i);
                return;
            end
        end
        n_fail++;
        end_sim;
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        reset_n_i <= 1'h1;
        @(posedge clk_i);
        axi_rd(ST, 32'h50, OK);
        cmp("bus32", 32'h0, bus_32bit_o);
        cmp("speed", 32'h0, speed_strap_o);
        cmp("xover", 32'h1, auto_crossover_en_o);
        axi_rd(8'h10, 32'h0, ERR);
        axi_wr(8'h10, 32'h1, ERR);
        axi_wr(MK, 32'h7, OK);
        i_rwsc_host_model.cycle(1'h1);
        axi_rd(IS, 32'h4, OK);
        cmp("irq", 32'h1, irq_o);
        axi_wr(IS, 32'h4, OK);
        axi_rd(IS, 32'h0, OK);
        cmp("irq", 32'h0, irq_o);
        i_rwsc_host_model.cycle(1'h0);
        i_rwsc_host_model.cycle(1'h1);
        cmp("accepts", 32'h1, n_acc);
        {speed_strap_i, bus_width_strap_i} <= 2'h3;
        axi_rd(ST, 32'h52, OK);
        axi_wr(CT, 32'h1, OK);
        hw_reset_n_i <= 1'h0;
        repeat (3) @(posedge clk_i);
        hw_reset_n_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        axi_rd(CT, 32'h0, OK);
        axi_rd(MK, 32'h0, OK);
        axi_rd(ST, 32'h5c, OK);
        cmp("bus32", 32'h1, bus_32bit_o);
        {auto_crossover_enable_i, s_axi_wstrb} <= 5'h0e;
        axi_wr(CT, 32'h1, OK);
        s_axi_wstrb <= 4'hf;
        axi_rd(CT, 32'h0, OK);
        cmp("xover", 32'h0, auto_crossover_en_o);
        i_rwsc_host_model.cycle(1'h1);
        i_rwsc_host_model.cycle(1'h0);
        axi_wr(CT, 32'hb, OK);
        @(posedge clk_i);
        cmp("pin", 32'h0, wake_indicator_o);
        wake_event_i <= 1'h1;
        @(posedge clk_i);
        wake_event_i <= 1'h0;
        repeat (4) @(posedge clk_i);
        cmp("pin", 32'h1, wake_indicator_o);
        i_rwsc_host_model.cycle(1'h0);
        cmp("asleep", 32'h1, power_save_o);
        axi_rd(IS, 32'h5, OK);
        cmp("irq", 32'h0, irq_o);
        axi_wr(CT, 32'hf, OK);
        @(posedge clk_i);
        cmp("pin oe", 32'h0, wake_indicator_oe_o);
        axi_wr(CT, 32'hd, OK);
        @(posedge clk_i);
        cmp("pin oe", 32'h1, wake_indicator_oe_o);
        i_rwsc_host_model.cycle(1'h1);
        repeat (2) @(posedge clk_i);
        cmp("asleep", 32'h0, power_save_o);
        cmp("accepts", 32'h1, n_acc);
        cmp("pin oe", 32'h0, wake_indicator_oe_o);
        axi_rd(IS, 32'h7, OK);
        end_sim;
    end
endmodule // test_rwsc_top
